/* File: gpib_command_input_parser.sv */
// Remote command input path: filters bus characters into a 31-place buffer,
// executes terminated strings in order and keeps the output buffer status.
// Assumes a bus controller front end that delivers bytes with valid/ready,
// reports EOI and GET with a byte word, and pulses DCL/SDC on bus_dcl.
// What this block does
// - Hold incoming command characters in a 31-place continuous buffer.
// - No execution or syntax check before a terminator or a full buffer.
// - CR, LF, GET and EOI are the only terminators; each runs its string.
// - Execute commands in arrival order, freeing space per character.
// - Full buffer stalls the bus until one executed character frees a place.
// - Upper and lower case letters are equivalent.
// - Drop spaces, commas and control codes other than CR and LF.
// - A run of CR, LF and EOI terminators stores a single terminator; every GET is stored.
// - Numbers may be integer, real or real with exponent.
// - Command letters need exactly one variant digit.
// - N, E, point, plus, minus and digits build a number.
// - Error characters and letters raise error 71 and the annunciator.
// - Illegal command loads an error, is skipped, changes nothing.
// - Output buffer clears once read; continuous mode refills it.
// - One output buffer; the last output command of a string wins.
// - Data available drops on read done or a new terminator.
// - Query commands, single trigger, continuous trigger and GET load output.
// - Finish the buffered string before loading output; then set available.
// - Data available is status bit 5, any error is bit 6.
// - DCL or SDC empties the whole input buffer at once.
`timescale 1ns/100ps

`include "gpib_parser_defines.svh"

module gpib_command_input_parser
  import gpib_parser_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Bus data bytes from the listener
  input wire logic [7:0] bus_data,
  input wire logic bus_valid,
  input wire logic bus_eoi,
  input wire logic bus_get,
  output logic bus_ready,
  // Device clear from the bus
  input wire logic bus_dcl,
  // Output buffer events
  input wire logic out_read_done,
  input wire logic talk_busy,
  input wire logic reading_ready,
  // Decoded commands
  output logic cmd_valid,
  output logic [7:0] cmd_letter,
  output logic [3:0] cmd_digit,
  output logic num_valid,
  output logic [7:0] num_char,
  output logic err_valid,
  output logic [7:0] err_code,
  // Output buffer and status
  output logic out_load,
  output logic [7:0] out_src,
  output logic data_avail,
  output logic any_error,
  output logic cont_mode,
  output logic [7:0] status_byte
);

  parse_state_s st_ff;
  parse_state_s nxt_st;
  logic [`SKID_W-1:0] sk_data;
  logic sk_valid;
  logic sink_ready;
  logic [7:0] wch;
  logic [7:0] c;
  logic push;
  logic [7:0] pdata;
  logic term_push;
  logic pop;
  logic term_pop;
  logic exec_go;
  logic load_now;
  logic err_hit;
  logic [7:0] err_c;

  // Characters that never reach the buffer
  function automatic logic is_ignored(input logic [7:0] ch);
    return (ch == `CH_SP) || (ch == `CH_COMMA) || (ch == `CH_DEL)
      || ((ch < `CH_SP) && (ch != `CH_CR) && (ch != `CH_LF));
  endfunction

  function automatic logic is_cmd_letter(input logic [7:0] ch);
    logic [25:0] mask;
    mask = `CMD_LETTER_MASK;
    return (ch >= `CH_A) && (ch <= `CH_Z) && mask[5'(ch - `CH_A)];
  endfunction

  function automatic logic [3:0] max_variant(input logic [7:0] ch);
    logic [3:0] m;
    m = `MAXV_DEF;
    if (ch == `CH_G) m = `MAXV_G;
    if (ch == `CH_T) m = `MAXV_T;
    if (ch == `CH_R) m = `MAXV_R;
    if (ch == `CH_F) m = `MAXV_F;
    if (ch == `CH_X) m = `MAXV_X;
    if (ch == `CH_Z_CMD) m = `MAXV_Z;
    return m;
  endfunction

  // Skid buffer keeps words that arrive while the filter stalls
  gpib_skid_buffer u_skid (
    .core_clk(core_clk),
    .nrst(nrst),
    .flush(bus_dcl),
    .in_data({bus_get, bus_eoi, bus_data}),
    .in_valid(bus_valid),
    .in_ready(bus_ready),
    .out_data(sk_data),
    .out_valid(sk_valid),
    .out_ready(sink_ready)
  );

  // Filter, buffer and executor
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.out_load = 1'b0;
    nxt_st.cmd_valid = 1'b0;
    nxt_st.num_valid = 1'b0;
    nxt_st.err_valid = 1'b0;
    push = 1'b0;
    pdata = 8'h00;
    term_push = 1'b0;
    pop = 1'b0;
    term_pop = 1'b0;
    load_now = 1'b0;
    err_hit = 1'b0;
    err_c = `ERR_SYNTAX;
    wch = sk_data[7:0];
    // Stop taking words while full; bus ready falls once the skid fills
    sink_ready = !st_ff.eoi_pend && (st_ff.cnt != `IBUF_DEPTH);
    if (st_ff.eoi_pend && (st_ff.cnt != `IBUF_DEPTH))
    begin
      push = 1'b1; // EOI terminator stored after its data byte
      pdata = `TOK_TERM;
      term_push = 1'b1;
      nxt_st.eoi_pend = 1'b0;
      nxt_st.last_term = 1'b1;
    end
    else if (sk_valid && sink_ready)
    begin
      if (sk_data[`SKID_GET])
      begin
        push = 1'b1; // GET ends the string and triggers
        pdata = `TOK_GET;
        term_push = 1'b1;
        nxt_st.last_term = 1'b1;
      end
      else if ((wch == `CH_CR) || (wch == `CH_LF) || (sk_data[`SKID_EOI] && is_ignored(wch)))
      begin
        if (!st_ff.last_term)
        begin
          push = 1'b1; // only the first of a run is stored
          pdata = `TOK_TERM;
          term_push = 1'b1;
        end
        nxt_st.last_term = 1'b1;
      end
      else if (!is_ignored(wch))
      begin
        push = 1'b1;
        pdata = ((wch >= `CH_LO_A) && (wch <= `CH_LO_Z)) ? (wch - `CASE_BIT) : wch;
        nxt_st.last_term = 1'b0;
        nxt_st.eoi_pend = sk_data[`SKID_EOI];
      end
    end
    if (push)
    begin
      nxt_st.mem[st_ff.wr_ptr] = pdata;
      nxt_st.wr_ptr = (st_ff.wr_ptr == `IBUF_LAST) ? 5'h00 : 5'(st_ff.wr_ptr + 5'h01);
    end
    // Run only on a stored terminator or a full buffer
    exec_go = (st_ff.cnt != 6'h00) && ((st_ff.term_cnt != 6'h00) || (st_ff.cnt == `IBUF_DEPTH));
    c = st_ff.mem[st_ff.rd_ptr];
    if (exec_go)
    begin
      pop = 1'b1; // one character per cycle, oldest first
      nxt_st.rd_ptr = (st_ff.rd_ptr == `IBUF_LAST) ? 5'h00 : 5'(st_ff.rd_ptr + 5'h01);
      if ((c == `TOK_TERM) || (c == `TOK_GET))
      begin
        term_pop = 1'b1;
        err_hit = st_ff.expect_digit; // letter without its digit
        nxt_st.expect_digit = 1'b0;
        load_now = st_ff.pend_load || st_ff.pend_err || err_hit || (c == `TOK_GET);
        nxt_st.out_src = st_ff.pend_src; // last output command wins
        if (c == `TOK_GET)
          nxt_st.out_src = `SRC_GET;
        if (st_ff.pend_err || err_hit)
          nxt_st.out_src = `SRC_ERR;
        nxt_st.pend_load = 1'b0;
        nxt_st.pend_err = 1'b0;
      end
      else if (st_ff.expect_digit)
      begin
        nxt_st.expect_digit = 1'b0;
        if ((c < `CH_0) || (c > `CH_9))
        begin
          err_hit = 1'b1;
        end
        else if (c[3:0] > max_variant(st_ff.letter))
        begin
          err_hit = 1'b1; // skipped with no effect on configuration
          err_c = `ERR_ILLEGAL;
        end
        else
        begin
          nxt_st.cmd_valid = 1'b1;
          nxt_st.cmd_letter = st_ff.letter;
          nxt_st.cmd_digit = c[3:0];
          if (st_ff.letter == `CH_T)
            nxt_st.cont_mode = (c == `CH_0);
          if ((st_ff.letter == `CH_G) || ((st_ff.letter == `CH_T) && (c == `CH_0)))
          begin
            nxt_st.pend_load = 1'b1; // query and continuous trigger load
            nxt_st.pend_src = st_ff.letter;
          end
          if (st_ff.letter == `CH_X)
            nxt_st.any_error = 1'b0;
        end
      end
      else if (is_cmd_letter(c))
      begin
        nxt_st.expect_digit = 1'b1;
        nxt_st.letter = c;
      end
      else if (((c >= `CH_0) && (c <= `CH_9)) || (c == `CH_N) || (c == `CH_E)
        || (c == `CH_DOT) || (c == `CH_PLUS) || (c == `CH_MINUS))
      begin
        nxt_st.num_valid = 1'b1; // NR1, NR2 and NR3 characters pass on
        nxt_st.num_char = c;
      end
      else if (c == `CH_QUERY)
      begin
        nxt_st.cmd_valid = 1'b1;
        nxt_st.cmd_letter = c;
        nxt_st.cmd_digit = 4'h0;
        nxt_st.pend_load = 1'b1; // single trigger loads output
        nxt_st.pend_src = c;
      end
      else if (c == `CH_STAR)
      begin
        nxt_st.cmd_valid = 1'b1;
        nxt_st.cmd_letter = c;
        nxt_st.cmd_digit = 4'h0;
        nxt_st.cont_mode = 1'b1;
        nxt_st.any_error = 1'b0;
      end
      else
      begin
        err_hit = 1'b1;
      end
    end
    // Errors light the annunciator and queue an error message
    if (err_hit)
    begin
      nxt_st.err_valid = 1'b1;
      nxt_st.err_code = err_c;
      nxt_st.any_error = 1'b1;
      nxt_st.pend_err = !term_pop;
    end
    nxt_st.cnt = 6'(st_ff.cnt + 6'(push) - 6'(pop));
    nxt_st.term_cnt = 6'(st_ff.term_cnt + 6'(term_push) - 6'(term_pop));
    // Device clear empties the input buffer at once
    if (bus_dcl)
    begin
      nxt_st.rd_ptr = 5'h00;
      nxt_st.wr_ptr = 5'h00;
      nxt_st.cnt = 6'h00;
      nxt_st.term_cnt = 6'h00;
      nxt_st.eoi_pend = 1'b0;
      nxt_st.last_term = 1'b0;
      nxt_st.expect_digit = 1'b0;
      nxt_st.pend_load = 1'b0;
      nxt_st.pend_err = 1'b0;
      load_now = 1'b0;
    end
    // Output buffer status: clears first, loads win in the same cycle
    if (out_read_done || term_push)
      nxt_st.data_avail = 1'b0;
    if (load_now)
    begin
      nxt_st.data_avail = 1'b1;
      nxt_st.out_load = 1'b1;
    end
    else if (reading_ready && st_ff.cont_mode && !talk_busy)
    begin
      nxt_st.data_avail = 1'b1; // continuous readings refill
      nxt_st.out_load = 1'b1;
      nxt_st.out_src = `SRC_CONT;
    end
    nxt_st.status_byte = 8'h00;
    nxt_st.status_byte[`SPB_AVAIL] = nxt_st.data_avail;
    nxt_st.status_byte[`SPB_ERR] = nxt_st.any_error;
  end

  // State register; continuous trigger is the power-up mode
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= '0;
      st_ff.cont_mode <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign cmd_valid = st_ff.cmd_valid;
  assign cmd_letter = st_ff.cmd_letter;
  assign cmd_digit = st_ff.cmd_digit;
  assign num_valid = st_ff.num_valid;
  assign num_char = st_ff.num_char;
  assign err_valid = st_ff.err_valid;
  assign err_code = st_ff.err_code;
  assign out_load = st_ff.out_load;
  assign out_src = st_ff.out_src;
  assign data_avail = st_ff.data_avail;
  assign any_error = st_ff.any_error;
  assign cont_mode = st_ff.cont_mode;
  assign status_byte = st_ff.status_byte;

  // Checks
  sequence s_string_end;
    pop && term_pop && !bus_dcl;
  endsequence

  sequence s_loaded;
    out_load && data_avail;
  endsequence

  AST_CNT_MAX: assert property (@(posedge core_clk) disable iff (!nrst)
    st_ff.cnt <= `IBUF_DEPTH) else $error("input buffer count above 31");
  AST_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_ff.term_cnt == 6'h00) && (st_ff.cnt != `IBUF_DEPTH) |-> !pop)
    else $error("character executed with no terminator and buffer not full");
  AST_FULL_STALL: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_ff.cnt == `IBUF_DEPTH) |-> !sink_ready) else $error("word taken while full");
  AST_UPPER: assert property (@(posedge core_clk) disable iff (!nrst)
    push |-> !((pdata >= `CH_LO_A) && (pdata <= `CH_LO_Z))) else $error("lower case stored");
  AST_ONE_TERM: assert property (@(posedge core_clk) disable iff (!nrst)
    term_push && (pdata == `TOK_TERM) && !bus_dcl |=> !(term_push && (pdata == `TOK_TERM)) [*1])
    else $error("two terminators stored back to back");
  AST_ERR71: assert property (@(posedge core_clk) disable iff (!nrst)
    err_valid && (err_code == `ERR_SYNTAX) |-> any_error && status_byte[`SPB_ERR])
    else $error("syntax error without annunciator");
  AST_END_LOAD: assert property (@(posedge core_clk) disable iff (!nrst)
    s_string_end ##0 (st_ff.pend_load || (c == `TOK_GET)) |=> s_loaded)
    else $error("string end did not load output buffer");
  AST_READ_CLR: assert property (@(posedge core_clk) disable iff (!nrst)
    out_read_done && !load_now && !(reading_ready && cont_mode && !talk_busy)
    |=> !data_avail ##1 !data_avail || out_load || $rose(data_avail))
    else $error("data available stayed after read");
  AST_STATUS: assert property (@(posedge core_clk) disable iff (!nrst)
    (status_byte[`SPB_AVAIL] == data_avail) && (status_byte[`SPB_ERR] == any_error))
    else $error("status byte bits mismatch");
  AST_DCL: assert property (@(posedge core_clk) disable iff (!nrst)
    bus_dcl |=> (st_ff.cnt == 6'h00) && (st_ff.term_cnt == 6'h00))
    else $error("device clear left characters buffered");

endmodule

/* File: gpib_parser_defines.svh */
// Constants of the remote command input parser: buffer sizes, character codes,
// command variant limits, error codes and status byte bit positions.
// Assumes ASCII bytes from the bus and a single 200 MHz core clock.
`ifndef GPIB_PARSER_DEFINES_SVH
`define GPIB_PARSER_DEFINES_SVH

// Input buffer geometry
`define IBUF_DEPTH 6'h1F
`define IBUF_LAST 5'h1E
// Skid buffer word: {get, eoi, data}
`define SKID_W 10
`define SKID_GET 9
`define SKID_EOI 8

// Tokens stored in place of terminators
`define TOK_TERM 8'h0A
`define TOK_GET 8'h01

// Character codes
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CH_SP 8'h20
`define CH_COMMA 8'h2C
`define CH_DEL 8'h7F
`define CH_LO_A 8'h61
`define CH_LO_Z 8'h7A
`define CASE_BIT 8'h20
`define CH_A 8'h41
`define CH_Z 8'h5A
`define CH_0 8'h30
`define CH_9 8'h39
`define CH_N 8'h4E
`define CH_E 8'h45
`define CH_DOT 8'h2E
`define CH_PLUS 8'h2B
`define CH_MINUS 8'h2D
`define CH_QUERY 8'h3F
`define CH_STAR 8'h2A
`define CH_G 8'h47
`define CH_T 8'h54
`define CH_X 8'h58
`define CH_R 8'h52
`define CH_F 8'h46
`define CH_Z_CMD 8'h5A

// Command letters B C D F G P R S T W X Y Z as a mask over A..Z
`define CMD_LETTER_MASK 26'h3CE806E

// Highest legal variant digit per command letter
`define MAXV_G 4'h8
`define MAXV_T 4'h4
`define MAXV_R 4'h8
`define MAXV_F 4'h6
`define MAXV_X 4'h0
`define MAXV_Z 4'h0
`define MAXV_DEF 4'h9

// Error codes and output buffer sources
`define ERR_SYNTAX 8'h47
`define ERR_ILLEGAL 8'h33
`define SRC_ERR 8'h45
`define SRC_CONT 8'h43
`define SRC_GET 8'h01

// Serial poll status byte bits
`define SPB_AVAIL 5
`define SPB_ERR 6

`endif

/* File: gpib_parser_pkg.sv */
// State types of the command input parser and its skid buffer.
// Assumes gpib_parser_defines.svh is on the include path.
`include "gpib_parser_defines.svh"

package gpib_parser_pkg;

  typedef struct packed {
    logic [1:0][`SKID_W-1:0] word;
    logic [1:0] fill;
    logic in_ready;
  } skid_state_s;

  typedef struct packed {
    logic [30:0][7:0] mem;
    logic [4:0] rd_ptr;
    logic [4:0] wr_ptr;
    logic [5:0] cnt;
    logic [5:0] term_cnt;
    logic last_term;
    logic eoi_pend;
    logic expect_digit;
    logic [7:0] letter;
    logic pend_load;
    logic [7:0] pend_src;
    logic pend_err;
    logic cont_mode;
    logic data_avail;
    logic any_error;
    logic [7:0] status_byte;
    logic out_load;
    logic [7:0] out_src;
    logic cmd_valid;
    logic [7:0] cmd_letter;
    logic [3:0] cmd_digit;
    logic num_valid;
    logic [7:0] num_char;
    logic err_valid;
    logic [7:0] err_code;
  } parse_state_s;

endpackage

/* File: gpib_skid_buffer.sv */
// Two-entry buffer between the bus byte port and the character filter.
// Assumes the sink may stall at any time; a flush empties both entries.
`timescale 1ns/100ps

`include "gpib_parser_defines.svh"

module gpib_skid_buffer
  import gpib_parser_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic flush,
  // Filling side
  input wire logic [`SKID_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [`SKID_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  skid_state_s st_ff;
  skid_state_s nxt_st;
  logic push;
  logic pop;

  // Entry 0 is always the oldest word
  always_comb
  begin
    nxt_st = st_ff;
    push = in_valid && st_ff.in_ready;
    pop = out_ready && (st_ff.fill != 2'h0);
    if (pop)
    begin
      nxt_st.word[0] = st_ff.word[1];
    end
    if (push)
    begin
      nxt_st.word[2'(st_ff.fill) - 2'(pop)] = in_data;
    end
    nxt_st.fill = 2'(st_ff.fill + 2'(push) - 2'(pop));
    if (flush)
    begin
      nxt_st.fill = 2'h0;
    end
    // Ready is registered, so it only promises room for one more word
    nxt_st.in_ready = (nxt_st.fill != 2'h2);
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready = st_ff.in_ready;
  assign out_valid = (st_ff.fill != 2'h0);
  assign out_data = st_ff.word[0];

endmodule

/* File: gpib_bus_ctrl_model.sv */
// Behavioural bus controller that offers command words to the parser.
// Assumes the parser takes a word at a rising edge with bus_valid and bus_ready high.
`timescale 1ns/100ps

module gpib_bus_ctrl_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Word port toward the parser
  output logic [7:0] bus_data,
  output logic bus_valid,
  output logic bus_eoi,
  output logic bus_get,
  input wire logic bus_ready,
  // Pacing: random idle gaps between words when high
  input wire logic slow
);
  logic [9:0] words[$];
  logic [9:0] w;
  int gap = 0;
  integer seed = 32'hB5439185;

  // Queue a word {get, eoi, data} at the back of the list
  task automatic put(input logic [9:0] wd);
    words.push_back(wd);
  endtask

  // Offer words in order and hold each one until it is taken
  always @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      bus_valid <= 1'b0;
      bus_eoi <= 1'b0;
      bus_get <= 1'b0;
      bus_data <= 8'hA5;
    end
    else if (!bus_valid || bus_ready)
    begin
      if (bus_valid && slow)
        gap = $unsigned($random(seed)) % 4;
      if (gap > 0 || words.size() == 0)
      begin
        if (gap > 0)
          gap--;
        bus_valid <= 1'b0;
        bus_eoi <= 1'b0;
        bus_get <= 1'b0;
        bus_data <= ~bus_data; // Released lines keep no stale value
      end
      else
      begin
        w = words.pop_front();
        bus_data <= w[7:0];
        bus_eoi <= w[8];
        bus_get <= w[9];
        bus_valid <= 1'b1;
      end
    end
endmodule

/* File: tb_gpib_command_input_parser.sv */
// Self-checking bench of the command input parser with a bus controller model.
// Assumes the parser ports and constants of gpib_parser_defines.svh.
`timescale 1ns/100ps

`include "gpib_parser_defines.svh"

module tb_gpib_command_input_parser;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic bus_dcl = 1'b0;
  logic out_read_done = 1'b0;
  logic talk_busy = 1'b0;
  logic reading_ready = 1'b0;
  logic slow = 1'b1;
  logic [7:0] bus_data;
  logic bus_valid, bus_eoi, bus_get, bus_ready;
  logic cmd_valid, num_valid, err_valid, out_load, data_avail, any_error, cont_mode;
  logic [7:0] cmd_letter, num_char, err_code, out_src, status_byte;
  logic [3:0] cmd_digit;
  logic [19:0] exp_q[$];
  int n_mismatch = 0;
  int comparisons = 0;
  logic saw_stall = 1'b0;
  integer seed = 32'hB5439185;
  string s;

  gpib_bus_ctrl_model ctrl (.core_clk(core_clk), .nrst(nrst), .bus_data(bus_data),
    .bus_valid(bus_valid), .bus_eoi(bus_eoi), .bus_get(bus_get), .bus_ready(bus_ready),
    .slow(slow));

  gpib_command_input_parser uut (.core_clk(core_clk), .nrst(nrst), .bus_data(bus_data),
    .bus_valid(bus_valid), .bus_eoi(bus_eoi), .bus_get(bus_get), .bus_ready(bus_ready),
    .bus_dcl(bus_dcl), .out_read_done(out_read_done), .talk_busy(talk_busy),
    .reading_ready(reading_ready), .cmd_valid(cmd_valid), .cmd_letter(cmd_letter),
    .cmd_digit(cmd_digit), .num_valid(num_valid), .num_char(num_char),
    .err_valid(err_valid), .err_code(err_code), .out_load(out_load), .out_src(out_src),
    .data_avail(data_avail), .any_error(any_error), .cont_mode(cont_mode),
    .status_byte(status_byte));

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  // Result note: {kind, value, detail}; kind 1 command, 2 number, 3 error, 4 load
  function automatic logic [19:0] note(input logic [3:0] k, input logic [7:0] a,
                                       input logic [7:0] b);
    return {k, a, b};
  endfunction

  // Compare one value and count it
  task automatic check(input logic [19:0] seen, input logic [19:0] want);
    comparisons++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // Take the oldest note for an observed result
  task automatic take(input logic [19:0] seen);
    logic [19:0] want;
    want = (exp_q.size() > 0) ? exp_q.pop_front() : 20'hFFFFF;
    check(seen, want);
  endtask

  // Result watcher
  always @(negedge core_clk)
    if (nrst)
    begin
      if (cmd_valid === 1'b1)
        take(note(4'h1, cmd_letter, {4'h0, cmd_digit}));
      if (num_valid === 1'b1)
        take(note(4'h2, num_char, 8'h00));
      if (err_valid === 1'b1)
        take(note(4'h3, err_code, 8'h00));
      if (out_load === 1'b1)
        take(note(4'h4, out_src, 8'h00));
      if (bus_valid && !bus_ready)
        saw_stall = 1'b1;
    end

  // Queue a string; the last character may carry EOI
  task automatic send(input string t, input logic eoi);
    for (int i = 0; i < t.len(); i++)
      ctrl.put({1'b0, eoi && (i == t.len() - 1), t[i]});
  endtask

  task automatic exp_cmd(input logic [7:0] l, input logic [7:0] d);
    exp_q.push_back(note(4'h1, l, d));
  endtask

  task automatic exp_one(input logic [3:0] k, input logic [7:0] v);
    exp_q.push_back(note(k, v, 8'h00));
  endtask

  task automatic pulse_read();
    @(posedge core_clk);
    out_read_done <= 1'b1;
    @(posedge core_clk);
    out_read_done <= 1'b0;
  endtask

  // Wait until every note is met and the controller is idle
  task automatic settle(input string name);
    int i;
    for (i = 0; i < 3000 && (exp_q.size() > 0 || ctrl.words.size() > 0 || bus_valid); i++)
      @(posedge core_clk);
    if (i == 3000)
    begin
      n_mismatch++;
      end_of_test();
    end
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    $display("Test %s done", name);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    #400000;
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    check({12'h0, status_byte}, 20'h0);
    check({19'h0, cont_mode}, 20'h1);
    // Case folding, ignored characters, nothing runs before a terminator
    send("f 3,\t", 1'b0);
    settle("hold");
    exp_cmd(8'h46, 8'h03);
    send("\n", 1'b0);
    settle("case");
    // Every command letter except T, a terminator group, then a read
    s = "BCDFGPRSWXYZ";
    for (int i = 0; i < s.len(); i++)
    begin
      send({s.substr(i, i), "0"}, 1'b0);
      exp_cmd(s[i], 8'h00);
    end
    exp_one(4'h4, 8'h47);
    send("\r", 1'b0);
    settle("letters");
    send("\n", 1'b1);
    settle("group");
    check({19'h0, data_avail}, 20'h1);
    check({12'h0, status_byte}, 20'h20);
    pulse_read();
    @(negedge core_clk);
    check({12'h0, status_byte}, 20'h0);
    // Numeric entry characters
    s = "NE.+-0123456789";
    for (int i = 0; i < s.len(); i++)
      exp_one(4'h2, s[i]);
    send({s, "\n"}, 1'b0);
    settle("numbers");
    check({19'h0, data_avail}, 20'h0);
    // Error characters
    s = "HIJKLMOQUV!#@";
    for (int i = 0; i < s.len(); i++)
      exp_one(4'h3, `ERR_SYNTAX);
    exp_one(4'h4, `SRC_ERR);
    send({s, "\r"}, 1'b0);
    settle("syntax");
    check({12'h0, status_byte}, 20'h60);
    pulse_read();
    exp_cmd(8'h58, 8'h00);
    send("x0\n", 1'b0);
    settle("clear");
    check({19'h0, any_error}, 20'h0);
    // Illegal variants leave the mode alone
    exp_cmd(8'h54, 8'h01);
    exp_one(4'h3, `ERR_ILLEGAL);
    exp_one(4'h3, `ERR_ILLEGAL);
    exp_one(4'h4, `SRC_ERR);
    send("T1F9T5\n", 1'b0);
    settle("illegal");
    check({19'h0, cont_mode}, 20'h0);
    pulse_read();
    // Two output commands: only the last survives
    exp_cmd(8'h47, 8'h00);
    exp_cmd(8'h3F, 8'h00);
    exp_one(4'h4, 8'h3F);
    send("G0?\n", 1'b0);
    settle("overwrite");
    pulse_read();
    exp_cmd(8'h2A, 8'h00);
    send("*\n", 1'b0);
    settle("star");
    check({19'h0, cont_mode}, 20'h1);
    // Continuous readings, blocked while talking
    @(posedge core_clk);
    talk_busy <= 1'b1;
    reading_ready <= 1'b1;
    @(posedge core_clk);
    talk_busy <= 1'b0;
    reading_ready <= 1'b0;
    exp_one(4'h4, `SRC_CONT);
    @(posedge core_clk);
    reading_ready <= 1'b1;
    @(posedge core_clk);
    reading_ready <= 1'b0;
    settle("continuous");
    pulse_read();
    // Continuous trigger command and the bus trigger message
    exp_cmd(8'h54, 8'h00);
    exp_one(4'h4, 8'h54);
    send("T0\n", 1'b0);
    settle("t0");
    pulse_read();
    exp_one(4'h4, `SRC_GET);
    ctrl.put(10'h200);
    settle("get");
    // A new terminator drops pending output
    exp_cmd(8'h47, 8'h01);
    exp_one(4'h4, 8'h47);
    send("G1\n", 1'b0);
    settle("pending");
    exp_cmd(8'h46, 8'h01);
    send("F1\n", 1'b0);
    settle("newterm");
    check({19'h0, data_avail}, 20'h0);
    // Overfill the input buffer at full rate
    slow <= 1'b0;
    s = "";
    for (int i = 0; i < 40; i++)
      s = {s, string'(8'h30 + 8'($unsigned($random(seed)) % 10))};
    send(s.substr(0, 19), 1'b0);
    settle("fill");
    for (int i = 0; i < 40; i++)
      exp_one(4'h2, s[i]);
    send({s.substr(20, 39), "\n"}, 1'b0);
    settle("full");
    check({19'h0, saw_stall}, 20'h1);
    slow <= 1'b1;
    // Device clear empties the buffer
    send("F2", 1'b0);
    settle("partial");
    @(posedge core_clk);
    bus_dcl <= 1'b1;
    @(posedge core_clk);
    bus_dcl <= 1'b0;
    exp_cmd(8'h46, 8'h03);
    send("\nF3\n", 1'b0);
    settle("dcl");
    end_of_test();
  end
endmodule
